/* design/lsu_addr_defs.svh */
`ifndef LSU_ADDR_DEFS_SVH
`define LSU_ADDR_DEFS_SVH
`define IMM_MAX_OFFSET 13'h0fff
`define IMM_MAX_INDEXED 13'h00ff
`define IMM_MAX_NEG 13'h00ff
`define PAIR_MAX_OFFSET 13'h03fc
`define PAIR_STEP 32'h0000_0004
`define PC_REG_NUM 4'hf
`define SP_REG_NUM 4'hd
`endif

/* design/lsu_addr_pkg.sv */
package lsu_addr_pkg;
  typedef enum logic [1:0] {MODE_OFFSET, MODE_PRE, MODE_POST} index_mode_type;
  typedef enum logic [2:0] {SZ_BYTE, SZ_SBYTE, SZ_HALF, SZ_SHALF, SZ_WORD, SZ_PAIR} size_type;
  typedef struct packed {
    logic load_op;
    logic reg_form;
    index_mode_type mode;
    size_type size;
    logic subtract;
    logic [11:0] imm;
    logic [1:0] shift_left;
    logic [3:0] transfer_reg;
    logic [3:0] second_transfer_reg;
    logic [3:0] base_reg;
    logic [31:0] base_val;
    logic [31:0] index_val;
    logic [31:0] store_val;
    logic [31:0] store_val2;
  } issue_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [1:0] bytes_log2;
    logic [31:0] wdata;
  } mem_req_type;
  typedef struct packed {
    logic valid;
    logic [3:0] reg_num;
    logic [31:0] value;
  } reg_wr_type;
endpackage

/* design/load_extend.sv */
`timescale 1ns/10ps
module load_extend
  import lsu_addr_pkg::*;
(
  input wire size_type size,
  input wire logic [31:0] raw,
  output logic [31:0] value
);
  always_comb
  begin
    unique case (size)
      SZ_BYTE: value = {24'h000000, raw[7:0]};
      SZ_SBYTE: value = {{24{raw[7]}}, raw[7:0]};
      SZ_HALF: value = {16'h0000, raw[15:0]};
      SZ_SHALF: value = {{16{raw[15]}}, raw[15:0]};
      SZ_WORD, SZ_PAIR: value = raw;
      default: value = raw;
    endcase
  end
endmodule

/* design/load_store_address_unit.sv */
`timescale 1ns/10ps
`include "lsu_addr_defs.svh"
module load_store_address_unit
  import lsu_addr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire issue_type issue,
  output logic issue_ready,
  output logic issue_fault,
  output mem_req_type mem_req,
  input wire logic mem_done,
  input wire logic [31:0] mem_rdata,
  output reg_wr_type reg_wr,
  output reg_wr_type base_wr,
  output logic branch_valid,
  output logic [31:0] branch_target
);
  // Flags are not an output at all: this unit can never touch them.
  typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} state_type;

  function automatic logic [1:0] size_log2(input size_type s);
    unique case (s)
      SZ_BYTE, SZ_SBYTE: size_log2 = 2'h0;
      SZ_HALF, SZ_SHALF: size_log2 = 2'h1;
      default: size_log2 = 2'h2;
    endcase
  endfunction

  state_type state_r, state_nxt;
  issue_type op_r, op_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic issue_ready_r, issue_ready_nxt;
  logic fault_r, fault_nxt;
  mem_req_type mem_r, mem_nxt;
  reg_wr_type reg_wr_r, reg_wr_nxt;
  reg_wr_type base_wr_r, base_wr_nxt;
  logic branch_r, branch_nxt;
  logic [31:0] target_r, target_nxt;
  logic [31:0] offset;
  logic [31:0] updated;
  logic [31:0] access;
  logic [12:0] imm13;
  logic legal;
  logic [31:0] ext_val;

  load_extend u_ext (
    .size(op_r.size),
    .raw(mem_rdata),
    .value(ext_val)
  );

  // Address and legality from the request as it stands
  always_comb
  begin
    imm13 = {1'b0, issue.imm};
    // Register form ignores mode and sign: it always adds
    if (issue.reg_form)
      offset = issue.index_val << issue.shift_left;
    else
      offset = {20'h00000, issue.imm};
    if (issue.subtract && !issue.reg_form)
      updated = issue.base_val - offset;
    else
      updated = issue.base_val + offset;
    access = (issue.mode == MODE_POST && !issue.reg_form) ? issue.base_val : updated;
    legal = 1'b1;
    if (issue.reg_form && issue.size == SZ_PAIR)
      legal = 1'b0;
    else if (!issue.reg_form && issue.size == SZ_PAIR)
      legal = (issue.imm[1:0] == 2'h0) && (imm13 <= `PAIR_MAX_OFFSET);
    else if (!issue.reg_form && issue.subtract)
      legal = imm13 <= `IMM_MAX_NEG;
    else if (!issue.reg_form && issue.mode != MODE_OFFSET)
      legal = imm13 <= `IMM_MAX_INDEXED;
    else if (!issue.reg_form)
      legal = imm13 <= `IMM_MAX_OFFSET;
    if (!issue.load_op && (issue.size == SZ_SBYTE || issue.size == SZ_SHALF))
      legal = 1'b0;
  end

  // Write back goes out with the request, not after the access
  always_comb
  begin
    state_nxt = state_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    issue_ready_nxt = issue_ready_r;
    fault_nxt = 1'b0;
    mem_nxt = mem_r;
    reg_wr_nxt = '0;
    base_wr_nxt = '0;
    branch_nxt = 1'b0;
    target_nxt = target_r;
    unique case (state_r)
      ST_IDLE:
      begin
        issue_ready_nxt = 1'b1;
        if (issue_valid && issue_ready_r)
        begin
          issue_ready_nxt = 1'b0;
          if (!legal)
          begin
            // Ready stays high on a refusal so issue can move on
            fault_nxt = 1'b1;
            issue_ready_nxt = 1'b1;
          end
          else
          begin
            op_nxt = issue;
            addr_nxt = access;
            mem_nxt.valid = 1'b1;
            mem_nxt.write = !issue.load_op;
            mem_nxt.addr = access;
            mem_nxt.bytes_log2 = size_log2(issue.size);
            mem_nxt.wdata = issue.store_val;
            if (issue.mode != MODE_OFFSET && !issue.reg_form)
            begin
              base_wr_nxt.valid = 1'b1;
              base_wr_nxt.reg_num = issue.base_reg;
              base_wr_nxt.value = updated;
            end
            state_nxt = ST_FIRST;
          end
        end
      end
      ST_FIRST:
      begin
        if (mem_done)
        begin
          mem_nxt.valid = 1'b0;
          if (op_r.load_op)
          begin
            // Branch replaces the register write for a word load into the counter
            if (op_r.transfer_reg == `PC_REG_NUM && op_r.size == SZ_WORD)
            begin
              branch_nxt = 1'b1;
              target_nxt = {mem_rdata[31:1], 1'b0};
            end
            else
            begin
              reg_wr_nxt.valid = 1'b1;
              reg_wr_nxt.reg_num = op_r.transfer_reg;
              reg_wr_nxt.value = ext_val;
            end
          end
          // Pair keeps valid high: the second beat follows with no gap
          if (op_r.size == SZ_PAIR)
          begin
            mem_nxt.valid = 1'b1;
            mem_nxt.addr = addr_r + `PAIR_STEP;
            mem_nxt.wdata = op_r.store_val2;
            state_nxt = ST_SECOND;
          end
          else
          begin
            issue_ready_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_SECOND:
      begin
        if (mem_done)
        begin
          mem_nxt.valid = 1'b0;
          if (op_r.load_op)
          begin
            reg_wr_nxt.valid = 1'b1;
            reg_wr_nxt.reg_num = op_r.second_transfer_reg;
            reg_wr_nxt.value = mem_rdata;
          end
          issue_ready_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  // Request held in op_r; issue may change once taken
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      op_r <= '0;
      addr_r <= 32'h0000_0000;
      issue_ready_r <= 1'b0;
      fault_r <= 1'b0;
      mem_r <= '0;
      reg_wr_r <= '0;
      base_wr_r <= '0;
      branch_r <= 1'b0;
      target_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      issue_ready_r <= issue_ready_nxt;
      fault_r <= fault_nxt;
      mem_r <= mem_nxt;
      reg_wr_r <= reg_wr_nxt;
      base_wr_r <= base_wr_nxt;
      branch_r <= branch_nxt;
      target_r <= target_nxt;
    end
  end

  assign issue_ready = issue_ready_r;
  assign issue_fault = fault_r;
  assign mem_req = mem_r;
  assign reg_wr = reg_wr_r;
  assign base_wr = base_wr_r;
  assign branch_valid = branch_r;
  assign branch_target = target_r;
endmodule

/* dv/lsu_mem_model.sv */
`timescale 1ns/10ps
module lsu_mem_model
  import lsu_addr_pkg::*;
(
  input wire logic core_clk,
  input wire mem_req_type mem_req,
  input wire logic [3:0] lat,
  input wire logic [31:0] pat,
  output logic mem_done,
  output logic [31:0] mem_rdata
);
  logic [3:0] cnt_r;
  // Scrambled outside the done cycle so stale data cannot pass
  assign mem_rdata = mem_done ? pat : ~pat;
  always_ff @(posedge core_clk)
  begin
    if (!mem_req.valid || mem_done)
    begin
      cnt_r <= 4'h0;
      mem_done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      mem_done <= (cnt_r == lat);
    end
  end
endmodule

/* dv/lsu_chk_sva.sv */
`timescale 1ns/10ps
module lsu_chk
  import lsu_addr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire issue_type issue,
  input wire logic issue_ready,
  input wire logic issue_fault,
  input wire mem_req_type mem_req,
  input wire reg_wr_type base_wr,
  input wire logic branch_valid,
  input wire logic [31:0] branch_target
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic take;
  assign take = issue_valid && issue_ready;
  a_fault_keeps_ready: assert property (issue_fault |-> issue_ready)
    else $error("fault dropped ready");
  a_range_indexed: assert property (take && !issue.reg_form && issue.mode != MODE_OFFSET
    && issue.size != SZ_PAIR && issue.imm > 12'h0ff |=> issue_fault)
    else $error("indexed offset not refused");
  a_pair_align: assert property (take && issue.size == SZ_PAIR && issue.imm[1:0] != 2'h0
    |=> issue_fault) else $error("odd pair offset taken");
  a_pair_reg_form: assert property (take && issue.reg_form && issue.size == SZ_PAIR
    |=> issue_fault) else $error("pair in register form taken");
  a_offset_no_wb: assert property (take && !issue.reg_form && issue.mode == MODE_OFFSET
    |=> !base_wr.valid) else $error("offset mode wrote base");
  a_pre_same_addr: assert property (base_wr.valid && $past(issue.mode) == MODE_PRE
    |-> mem_req.valid && mem_req.addr == base_wr.value) else $error("pre index mismatch");
  a_post_base_addr: assert property (base_wr.valid && $past(issue.mode) == MODE_POST
    |-> mem_req.addr == $past(issue.base_val)) else $error("post index address");
  a_reg_addr: assert property (take && issue.reg_form && issue.size == SZ_WORD |=>
    mem_req.addr == $past(issue.base_val) + ($past(issue.index_val) << $past(issue.shift_left)))
    else $error("register form address");
  a_branch_even: assert property (branch_valid |-> !branch_target[0])
    else $error("branch target odd");
endmodule
bind load_store_address_unit lsu_chk chk(.core_clk(core_clk), .rst_n(rst_n),
  .issue_valid(issue_valid), .issue(issue), .issue_ready(issue_ready),
  .issue_fault(issue_fault), .mem_req(mem_req), .base_wr(base_wr),
  .branch_valid(branch_valid), .branch_target(branch_target));

/* dv/load_store_address_unit_tb_top.sv */
`timescale 1ns/10ps
module load_store_address_unit_tb_top;
  import lsu_addr_pkg::*;
  logic core_clk = 0;
  logic rst_n = 0;
  logic issue_valid = 0;
  issue_type issue = '0;
  logic issue_ready, issue_fault, mem_done, branch_valid, flt, bwv, brv, rvv;
  mem_req_type mem_req;
  reg_wr_type reg_wr, base_wr;
  logic [31:0] mem_rdata, branch_target, rv, bw, bt;
  logic [31:0] pat = 32'h0;
  logic [3:0] lat = 4'h0;
  logic [31:0] a[2], w[2];
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  load_store_address_unit dut(.core_clk(core_clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue(issue), .issue_ready(issue_ready), .issue_fault(issue_fault), .mem_req(mem_req),
    .mem_done(mem_done), .mem_rdata(mem_rdata), .reg_wr(reg_wr), .base_wr(base_wr),
    .branch_valid(branch_valid), .branch_target(branch_target));
  lsu_mem_model mem(.core_clk(core_clk), .mem_req(mem_req), .lat(lat), .pat(pat),
    .mem_done(mem_done), .mem_rdata(mem_rdata));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic issue_type mk(logic ld, index_mode_type m, size_type s, logic [11:0] im);
    mk = '0;
    mk.load_op = ld;
    mk.mode = m;
    mk.size = s;
    mk.imm = im;
    mk.transfer_reg = 4'h1;
    mk.second_transfer_reg = 4'h2;
    mk.base_reg = 4'h3;
    mk.base_val = 32'h1000;
    mk.index_val = 32'h10;
    mk.store_val = 32'haabbccdd;
    mk.store_val2 = 32'h11223344;
  endfunction
  task automatic run(input issue_type op);
    int k;
    k = 0;
    {flt, bwv, brv, rvv} = 4'h0;
    @(negedge core_clk);
    issue = op;
    issue_valid = 1;
    @(negedge core_clk);
    issue_valid = 0;
    repeat (40)
    begin
      flt |= issue_fault;
      bwv |= base_wr.valid;
      brv |= branch_valid;
      rvv |= reg_wr.valid;
      if (base_wr.valid) bw = base_wr.value;
      if (reg_wr.valid) rv = reg_wr.value;
      if (branch_valid) bt = branch_target;
      if (mem_req.valid && mem_done) {a[k % 2], w[k % 2]} = {mem_req.addr, mem_req.wdata};
      if (mem_req.valid && mem_done) k++;
      if (issue_ready === 1'b1) break;
      @(negedge core_clk);
    end
  endtask
  task t_modes;
    issue_type op;
    run(mk(1, MODE_OFFSET, SZ_WORD, 12'h008));
    chk(a[0], 32'h1008);
    chk(32'(bwv), 32'h0);
    run(mk(1, MODE_PRE, SZ_WORD, 12'h0ff));
    chk(bw, 32'h10ff);
    op = mk(0, MODE_POST, SZ_HALF, 12'h0ff);
    op.subtract = 1;
    run(op);
    chk(a[0], 32'h1000);
    chk(bw, 32'h0f01);
    op = mk(0, MODE_PRE, SZ_PAIR, 12'h008);
    run(op);
    chk(a[1], 32'h100c);
    chk(w[0] ^ w[1], 32'hbb99ff99);
    op.reg_form = 1;
    op.size = SZ_WORD;
    op.shift_left = 2'h3;
    run(op);
    chk(a[0], 32'h1080);
    chk(32'(bwv), 32'h0);
    $display("modes test done");
  endtask
  task t_range;
    issue_type op;
    op = mk(1, MODE_OFFSET, SZ_BYTE, 12'hfff);
    run(op);
    chk(32'(flt), 32'h0);
    op.mode = MODE_PRE;
    op.imm = 12'h100;
    run(op);
    chk(32'(flt), 32'h1);
    op.mode = MODE_OFFSET;
    op.subtract = 1;
    run(op);
    chk(32'(flt), 32'h1);
    op = mk(0, MODE_POST, SZ_PAIR, 12'h3fc);
    run(op);
    chk(32'(flt), 32'h0);
    op.imm = 12'h400;
    run(op);
    chk(32'(flt), 32'h1);
    op.imm = 12'h006;
    run(op);
    chk(32'(flt), 32'h1);
    op.imm = 12'h0;
    op.reg_form = 1;
    run(op);
    chk(32'(flt), 32'h1);
    $display("range test done");
  endtask
  task t_load;
    size_type sz[5] = '{SZ_BYTE, SZ_SBYTE, SZ_HALF, SZ_SHALF, SZ_WORD};
    logic [31:0] ex[5] = '{32'h86, 32'hffffff86, 32'h8086, 32'hffff8086, 32'h12348086};
    issue_type op;
    pat = 32'h12348086;
    lat = 4'h3;
    foreach (sz[i])
    begin
      run(mk(1, MODE_OFFSET, sz[i], 12'h0));
      chk(rv, ex[i]);
    end
    pat = 32'h2001;
    op = mk(1, MODE_OFFSET, SZ_WORD, 12'h0);
    op.transfer_reg = 4'hf;
    run(op);
    chk(bt, 32'h2000);
    chk(32'({brv, rvv}), 32'h2);
    $display("load test done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial forever #12.5 core_clk = ~core_clk;
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_n = 1;
    repeat (3) @(negedge core_clk);
    t_modes;
    t_range;
    t_load;
    complete_run;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      complete_run;
    end
  end
endmodule
